// ---- shared/paired_timer_pkg.sv ----
package paired_timer_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 16;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_EVEN_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ODD_CONTROL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_EVEN_COUNT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ODD_COUNT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_EVEN_PERIOD = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ODD_PERIOD = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h20;

	// writable bit masks of the two control registers
	localparam logic [REG_W-1:0] EVEN_CTL_MASK = 16'hA07A;
	localparam logic [REG_W-1:0] ODD_CTL_MASK = 16'hA072;

	localparam logic [REG_W-1:0] CTL_RESET = 16'h0000;
	localparam logic [REG_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [REG_W-1:0] PERIOD_RESET = 16'hFFFF;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// terminal prescale counts, ratio minus one
	localparam logic [7:0] PRE_LIM_1 = 8'h00;
	localparam logic [7:0] PRE_LIM_8 = 8'h07;
	localparam logic [7:0] PRE_LIM_64 = 8'h3F;
	localparam logic [7:0] PRE_LIM_256 = 8'hFF;
	localparam logic [1:0] PS_1 = 2'h0;
	localparam logic [1:0] PS_8 = 2'h1;
	localparam logic [1:0] PS_64 = 2'h2;
	localparam logic [1:0] PS_256 = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int unsigned IRQ_EVEN_BIT = 0;
	localparam int unsigned IRQ_ODD_BIT = 1;

	typedef struct packed {
		logic on;
		logic rsv14;
		logic stop_in_idle;
		logic [5:0] rsv12_7;
		logic gated_accumulate_enable;
		logic [1:0] prescale_select;
		logic pair_32bit_select;
		logic rsv2;
		logic clock_source_select;
		logic rsv0;
	} ctl_type;

	typedef struct packed {
		logic even;
		logic odd;
	} timer_pins_type;
endpackage

// ---- logic/paired_timer_control.sv ----
// Overview of operation
// - prescale codes divide by 1, 8, 64, 256
// - clock source: external pin or half clock
// - stop_in_idle halts counting during idle mode
// - control write while on clears prescaler
// - unimplemented control bits read zero, ignore writes
// - pair select joins timers into 32 bits
// - timer_on bit starts and stops counting
// - odd count is high word, even low
// - 32-bit match raises the odd flag
//
// Register access over AXI4-Lite and the address map were left to the implementer.
module paired_timer_control (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// axi4-lite write address and data
	input wire logic [paired_timer_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [paired_timer_pkg::DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read
	input wire logic [paired_timer_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [paired_timer_pkg::DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// timer pins and device state
	input wire paired_timer_pkg::timer_pins_type ext_clk_i,
	input wire paired_timer_pkg::timer_pins_type gate_i,
	input wire logic idle_mode_i,
	// interrupt
	output logic irq_o
);
	import paired_timer_pkg::*;
	logic [REG_W-1:0] ctl_ff [2], cnt_ff [2], per_ff [2];
	logic [1:0] irq_status_ff, irq_enable_ff, bresp_ff, rresp_ff, ext_prev_ff;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic [DATA_W-1:0] w_data_ff, rdata_ff;
	logic [3:0] w_strb_ff;
	logic aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff, half_div_ff;
	logic [7:0] pre_ff [2];
	logic wr_en, irq_clr_wr, irq_en_wr, wr_hit, pair, match32;
	logic [1:0] ctl_wr, cnt_wr, per_wr, tick, ext_pin, gate_pin, match16, period_event;
	logic [31:0] nxt_cnt32;
	logic [REG_W-1:0] nxt_cnt0, nxt_cnt1;
	ctl_type even_ctl;
	function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old, input logic [DATA_W-1:0] d,
			input logic [3:0] s);
		logic [REG_W-1:0] r;
		r = old;
		if (s[0]) r[7:0] = d[7:0];
		if (s[1]) r[15:8] = d[15:8];
		return r;
	endfunction
	function automatic logic [7:0] pre_limit(input logic [1:0] ps);
		logic [7:0] r;
		r = PRE_LIM_1;
		unique case (ps)
			PS_1: r = PRE_LIM_1;
			PS_8: r = PRE_LIM_8;
			PS_64: r = PRE_LIM_64;
			PS_256: r = PRE_LIM_256;
		endcase
		return r;
	endfunction
	assign ext_pin = {ext_clk_i.odd, ext_clk_i.even};
	assign gate_pin = {gate_i.odd, gate_i.even};
	assign even_ctl = ctl_type'(ctl_ff[0]);
	assign pair = even_ctl.pair_32bit_select;
	// axi write channel: address and data accepted in either order
	assign s_axi_awready_o = !aw_full_ff && !bvalid_ff;
	assign s_axi_wready_o = !w_full_ff && !bvalid_ff;
	assign wr_en = aw_full_ff && w_full_ff && !bvalid_ff;
	assign s_axi_bvalid_o = bvalid_ff;
	assign s_axi_bresp_o = bresp_ff;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_full_ff <= 1'b0;
			aw_addr_ff <= '0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_full_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr_i;
		end else if (wr_en) begin
			aw_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			w_full_ff <= 1'b0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_full_ff <= 1'b1;
			w_data_ff <= s_axi_wdata_i;
			w_strb_ff <= s_axi_wstrb_i;
		end else if (wr_en) begin
			w_full_ff <= 1'b0;
		end
	end

	always_comb begin
		ctl_wr = '0;
		cnt_wr = '0;
		per_wr = '0;
		irq_clr_wr = 1'b0;
		irq_en_wr = 1'b0;
		wr_hit = 1'b1;
		unique case (aw_addr_ff)
			OFS_EVEN_CONTROL: ctl_wr[0] = wr_en;
			OFS_ODD_CONTROL: ctl_wr[1] = wr_en;
			OFS_EVEN_COUNT: cnt_wr[0] = wr_en;
			OFS_ODD_COUNT: cnt_wr[1] = wr_en;
			OFS_EVEN_PERIOD: per_wr[0] = wr_en;
			OFS_ODD_PERIOD: per_wr[1] = wr_en;
			OFS_IRQ_CLEAR: irq_clr_wr = wr_en;
			OFS_IRQ_ENABLE: irq_en_wr = wr_en;
			OFS_IRQ_STATUS: wr_hit = 1'b0;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_en) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_ff <= 1'b0;
		end
	end
	// axi read channel
	assign s_axi_arready_o = !rvalid_ff;
	assign s_axi_rvalid_o = rvalid_ff;
	assign s_axi_rdata_o = rdata_ff;
	assign s_axi_rresp_o = rresp_ff;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= '0;
			unique case (s_axi_araddr_i)
				OFS_EVEN_CONTROL: rdata_ff[REG_W-1:0] <= ctl_ff[0];
				OFS_ODD_CONTROL: rdata_ff[REG_W-1:0] <= ctl_ff[1];
				OFS_EVEN_COUNT: rdata_ff[REG_W-1:0] <= cnt_ff[0];
				OFS_ODD_COUNT: rdata_ff[REG_W-1:0] <= cnt_ff[1];
				OFS_EVEN_PERIOD: rdata_ff[REG_W-1:0] <= per_ff[0];
				OFS_ODD_PERIOD: rdata_ff[REG_W-1:0] <= per_ff[1];
				OFS_IRQ_STATUS: rdata_ff[1:0] <= irq_status_ff;
				OFS_IRQ_ENABLE: rdata_ff[1:0] <= irq_enable_ff;
				OFS_IRQ_CLEAR: rdata_ff <= '0;
				default: rresp_ff <= RESP_SLVERR;
			endcase
		end else if (s_axi_rready_i) begin
			rvalid_ff <= 1'b0;
		end
	end
	// control registers; unimplemented bits masked away so they stay zero
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_ff[0] <= CTL_RESET;
			ctl_ff[1] <= CTL_RESET;
		end else begin
			if (ctl_wr[0]) begin
				ctl_ff[0] <= merge(ctl_ff[0], w_data_ff, w_strb_ff) & EVEN_CTL_MASK;
			end
			if (ctl_wr[1]) begin
				ctl_ff[1] <= merge(ctl_ff[1], w_data_ff, w_strb_ff) & ODD_CTL_MASK;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			per_ff[0] <= PERIOD_RESET;
			per_ff[1] <= PERIOD_RESET;
		end else begin
			if (per_wr[0]) begin
				per_ff[0] <= merge(per_ff[0], w_data_ff, w_strb_ff);
			end
			if (per_wr[1]) begin
				per_ff[1] <= merge(per_ff[1], w_data_ff, w_strb_ff);
			end
		end
	end
	// internal count clock is half the system clock
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_div_ff <= 1'b0;
			ext_prev_ff <= '0;
		end else begin
			half_div_ff <= !half_div_ff;
			ext_prev_ff <= ext_pin;
		end
	end
	// per-timer clock selection, gating and prescale
	for (genvar i = 0; i < 2; i++) begin : g_timer
		ctl_type c;
		logic run, src;
		logic [7:0] lim;
		assign c = ctl_type'(ctl_ff[i]);
		assign run = c.on && !(c.stop_in_idle && idle_mode_i);
		// gate only applies to the internal clock
		assign src = c.clock_source_select ? (ext_pin[i] && !ext_prev_ff[i]) :
			(half_div_ff && (!c.gated_accumulate_enable || gate_pin[i]));
		assign lim = pre_limit(c.prescale_select);
		assign tick[i] = run && src && (pre_ff[i] >= lim);

		always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				pre_ff[i] <= '0;
			end else if (ctl_wr[i] && c.on) begin
				pre_ff[i] <= '0;
			end else if (run && src) begin
				pre_ff[i] <= (pre_ff[i] >= lim) ? 8'h00 : pre_ff[i] + 8'h01;
			end
		end
	end
	// count logic; a software write to a count wins over counting
	assign match16[0] = cnt_ff[0] == per_ff[0];
	assign match16[1] = cnt_ff[1] == per_ff[1];
	assign match32 = {cnt_ff[1], cnt_ff[0]} == {per_ff[1], per_ff[0]};
	assign nxt_cnt32 = {cnt_ff[1], cnt_ff[0]} + 32'h0000_0001;
	always_comb begin
		nxt_cnt0 = cnt_ff[0];
		nxt_cnt1 = cnt_ff[1];
		period_event = '0;
		if (pair) begin
			// odd prescaler and control ignored, even tick drives both words
			if (tick[0]) begin
				if (match32) begin
					nxt_cnt0 = COUNT_RESET;
					nxt_cnt1 = COUNT_RESET;
					period_event[IRQ_ODD_BIT] = 1'b1;
				end else begin
					nxt_cnt0 = nxt_cnt32[15:0];
					nxt_cnt1 = nxt_cnt32[31:16];
				end
			end
		end else begin
			if (tick[0]) begin
				nxt_cnt0 = match16[0] ? COUNT_RESET : cnt_ff[0] + 16'h0001;
				period_event[IRQ_EVEN_BIT] = match16[0];
			end
			if (tick[1]) begin
				nxt_cnt1 = match16[1] ? COUNT_RESET : cnt_ff[1] + 16'h0001;
				period_event[IRQ_ODD_BIT] = match16[1];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff[0] <= COUNT_RESET;
			cnt_ff[1] <= COUNT_RESET;
		end else begin
			cnt_ff[0] <= cnt_wr[0] ? merge(cnt_ff[0], w_data_ff, w_strb_ff) : nxt_cnt0;
			cnt_ff[1] <= cnt_wr[1] ? merge(cnt_ff[1], w_data_ff, w_strb_ff) : nxt_cnt1;
		end
	end
	// interrupt: an event in the clearing cycle survives
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_status_ff <= IRQ_RESET;
		end else if (irq_clr_wr && w_strb_ff[0]) begin
			irq_status_ff <= (irq_status_ff & ~w_data_ff[1:0]) | period_event;
		end else begin
			irq_status_ff <= irq_status_ff | period_event;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_enable_ff <= IRQ_RESET;
		end else if (irq_en_wr && w_strb_ff[0]) begin
			irq_enable_ff <= w_data_ff[1:0];
		end
	end
	assign irq_o = |(irq_status_ff & irq_enable_ff);
endmodule

// ---- dv/paired_timer_monitor.sv ----
module paired_timer_monitor import paired_timer_pkg::*; (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// write side
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// read side
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [DATA_W-1:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// interrupt
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [ADDR_W-1:0] rd_addr_ff;
	// address of the read in flight, so the answer can be judged
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rd_addr_ff <= 8'h00;
		else if (s_axi_arvalid_i && s_axi_arready_o)
			rd_addr_ff <= s_axi_araddr_i;
	end
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		|-> ##2 s_axi_bvalid_o) else $error("write not answered");
	a_bresp_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write answer dropped");
	a_write_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken during answer");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read not answered");
	a_rdata_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer dropped");
	a_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read taken during answer");
	a_even_ctl_zero: assert property (s_axi_rvalid_o && rd_addr_ff == OFS_EVEN_CONTROL |->
		(s_axi_rdata_o & ~{16'h0000, EVEN_CTL_MASK}) == 32'h0) else $error("even control spare bit set");
	a_odd_ctl_zero: assert property (s_axi_rvalid_o && rd_addr_ff == OFS_ODD_CONTROL |->
		(s_axi_rdata_o & ~{16'h0000, ODD_CTL_MASK}) == 32'h0) else $error("odd control spare bit set");
	a_unmapped_err: assert property (s_axi_rvalid_o && rd_addr_ff > OFS_IRQ_ENABLE |->
		s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("unmapped read accepted");
	cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
	cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
	cover property ($rose(irq_o));
endmodule

bind paired_timer_control paired_timer_monitor mon (.*);

// ---- dv/paired_timer_control_tb.sv ----
module paired_timer_control_tb;
	import paired_timer_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_i = 1'h0, rst_n_i = 1'h0, idle_mode_i = 1'h0;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	timer_pins_type ext_clk_i = 2'h0, gate_i = 2'h0;
	int err_total = 0, checked = 0;
	paired_timer_control dut (.*);
	initial begin
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
		checked++;
		// x on g makes the test non-one, so unknowns never pass
		if ((g >= lo && g <= hi) !== 1'b1) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		int n;
		logic aw_hs, w_hs, b_hs, b_seen;
		logic [1:0] resp;
		@(posedge sys_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		for (n = 0; n < 40; n++) begin
			// sampled mid-cycle: the readies are combinational and race the edge
			@(negedge sys_clk_i);
			aw_hs = s_axi_awvalid_i && s_axi_awready_o;
			w_hs = s_axi_wvalid_i && s_axi_wready_o;
			b_seen = s_axi_bvalid_o;
			b_hs = s_axi_bvalid_o && s_axi_bready_i;
			resp = s_axi_bresp_o;
			@(posedge sys_clk_i);
			if (aw_hs) s_axi_awvalid_i <= 1'h0;
			if (w_hs) s_axi_wvalid_i <= 1'h0;
			if (b_hs) break;
			// late bready makes the answer stand a cycle
			if (b_seen) s_axi_bready_i <= 1'h1;
		end
		s_axi_bready_i <= 1'h0;
		cmp(n < 40, 1, 1);
		if (n == 40) print_verdict();
		cmp(resp, r, r);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] lo, hi, input logic [1:0] r = RESP_OKAY);
		int n;
		logic ar_hs, r_hs, r_seen;
		logic [31:0] data;
		logic [1:0] resp;
		@(posedge sys_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(negedge sys_clk_i);
			ar_hs = s_axi_arvalid_i && s_axi_arready_o;
			r_seen = s_axi_rvalid_o;
			r_hs = s_axi_rvalid_o && s_axi_rready_i;
			data = s_axi_rdata_o;
			resp = s_axi_rresp_o;
			@(posedge sys_clk_i);
			if (ar_hs) s_axi_arvalid_i <= 1'h0;
			if (r_hs) break;
			if (r_seen) s_axi_rready_i <= 1'h1;
		end
		s_axi_rready_i <= 1'h0;
		cmp(n < 40, 1, 1);
		if (n == 40) print_verdict();
		cmp(data, lo, hi);
		cmp(resp, r, r);
	endtask
	task t_regs;
		rc(OFS_EVEN_PERIOD, 32'hFFFF, 32'hFFFF);
		wr(OFS_EVEN_CONTROL, 32'hFFFFFFFF);
		rc(OFS_EVEN_CONTROL, 32'hA07A, 32'hA07A);
		wr(OFS_ODD_CONTROL, 32'hFFFFFFFF);
		rc(OFS_ODD_CONTROL, 32'hA072, 32'hA072);
		wr(OFS_EVEN_CONTROL, 32'h0);
		wr(OFS_ODD_CONTROL, 32'h0);
		rc(8'h24, 32'h0, 32'h0, RESP_SLVERR);
		wr(OFS_IRQ_STATUS, 32'h3, RESP_SLVERR);
	endtask
	task t_scale;
		int r[4] = '{1, 8, 64, 256};
		// eight ticks per code: one tick per 2*ratio clocks; the two control writes add five
		for (int i = 0; i < 4; i++) begin
			wr(OFS_EVEN_COUNT, 32'h0);
			wr(OFS_EVEN_CONTROL, 32'h8000 | (i << 4));
			cyc(16 * r[i] - 4);
			wr(OFS_EVEN_CONTROL, 32'h0);
			rc(OFS_EVEN_COUNT, 7, 9);
		end
	endtask
	task t_idle;
		wr(OFS_EVEN_COUNT, 32'h0);
		idle_mode_i <= 1'h1;
		wr(OFS_EVEN_CONTROL, 32'hA000);
		cyc(40);
		rc(OFS_EVEN_COUNT, 0, 0);
		idle_mode_i <= 1'h0;
		cyc(40);
		wr(OFS_EVEN_CONTROL, 32'h0);
		rc(OFS_EVEN_COUNT, 18, 26);
	endtask
	task t_gate;
		wr(OFS_EVEN_COUNT, 32'h0);
		wr(OFS_EVEN_CONTROL, 32'h8042);
		repeat (10) begin
			ext_clk_i.even <= 1'h1;
			cyc(2);
			ext_clk_i.even <= 1'h0;
			cyc(2);
		end
		wr(OFS_EVEN_CONTROL, 32'h0);
		rc(OFS_EVEN_COUNT, 10, 10);
		for (int g = 0; g < 2; g++) begin
			gate_i.even <= g[0];
			wr(OFS_EVEN_COUNT, 32'h0);
			wr(OFS_EVEN_CONTROL, 32'h8040);
			cyc(20);
			wr(OFS_EVEN_CONTROL, 32'h0);
			rc(OFS_EVEN_COUNT, g * 9, g * 14);
		end
		gate_i.even <= 1'h0;
	endtask
	task t_clear;
		// prescaler would reach its terminal count without the rewrites
		wr(OFS_EVEN_COUNT, 32'h0);
		repeat (5) begin
			wr(OFS_EVEN_CONTROL, 32'h8030);
			cyc(200);
		end
		wr(OFS_EVEN_CONTROL, 32'h0);
		rc(OFS_EVEN_COUNT, 0, 0);
	endtask
	task t_pair;
		// pair first, so the odd timer that is switched on never counts alone
		wr(OFS_EVEN_CONTROL, 32'h0008);
		wr(OFS_ODD_CONTROL, 32'h8000);
		wr(OFS_EVEN_COUNT, 32'hFFFE);
		wr(OFS_ODD_COUNT, 32'h0);
		wr(OFS_EVEN_CONTROL, 32'h8008);
		cyc(20);
		wr(OFS_EVEN_CONTROL, 32'h0008);
		rc(OFS_ODD_COUNT, 1, 1);
		rc(OFS_EVEN_COUNT, 8, 14);
		wr(OFS_EVEN_COUNT, 32'h0);
		wr(OFS_ODD_COUNT, 32'h0);
		wr(OFS_EVEN_PERIOD, 32'h5);
		wr(OFS_ODD_PERIOD, 32'h0);
		wr(OFS_IRQ_ENABLE, 32'h1);
		wr(OFS_EVEN_CONTROL, 32'h8008);
		cyc(30);
		wr(OFS_EVEN_CONTROL, 32'h0008);
		rc(OFS_IRQ_STATUS, 32'h2, 32'h2);
		cmp(irq_o, 0, 0);
		wr(OFS_IRQ_ENABLE, 32'h3);
		cmp(irq_o, 1, 1);
		// odd timer off before unpairing, else period zero would refire its flag
		wr(OFS_ODD_CONTROL, 32'h0);
		wr(OFS_EVEN_CONTROL, 32'h0);
		wr(OFS_IRQ_CLEAR, 32'h3);
		cmp(irq_o, 0, 0);
		rc(OFS_IRQ_STATUS, 0, 0);
	endtask
	initial begin
		cyc(10);
		rst_n_i <= 1'h1;
		t_regs();
		t_scale();
		t_idle();
		t_gate();
		t_clear();
		t_pair();
		print_verdict();
	end
endmodule
